// >>> dpc_pkg.sv
// Constants, state encoding and timing counts for the DDR pSRAM host controller
package dpc_pkg;
    // Reference clock period and derived counts
    localparam int REF_PERIOD_NS = 25;
    localparam int MRST_TIME_NS = 200;
    localparam int MRST_CYC = (MRST_TIME_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
    localparam int CS_HIGH_NS = 50;
    localparam int CS_HIGH_CYC = (CS_HIGH_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
    // Initial access latency in bus clock cycles, doubled on refresh
    localparam int LAT_CYC = 6;
    localparam int LAT_EDGES = 2 * LAT_CYC;
    localparam int LAT_EDGES_REFRESH = 4 * LAT_CYC;
    // Read strobe silence allowed before the transaction is abandoned
    localparam int RD_IDLE_CYC = 64;
    // Command-address layout
    localparam int CA_BYTES = 6;
    localparam int CA_RW_BIT = 47;
    localparam int CA_SPACE_BIT = 46;
    localparam int CA_BURST_BIT = 45;
    localparam int CA_ROW_LSB = 16;
    localparam int CA_COL_W = 3;
    // Word address space: two dies of 2^24 16-bit words each
    localparam int ADDR_W = 25;
    localparam int DIE_LOG2 = 24;
    localparam int LEN_W = 9;
    localparam int CNT_W = 8;

    typedef enum logic [6:0] {
        ST_RESET = 7'h01,
        ST_IDLE = 7'h02,
        ST_CA = 7'h04,
        ST_LAT = 7'h08,
        ST_WRITE = 7'h10,
        ST_READ = 7'h20,
        ST_END = 7'h40
    } dpc_state_t;
endpackage : dpc_pkg

// >>> dpc_pin_sync.sv
// Three-stage synchroniser for pins sampled from the memory bus
`timescale 1ns/1ps
module dpc_pin_sync #(
    parameter int W = 9
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [W-1:0] pin_i,
    output logic [W-1:0] stage2_o,
    output logic [W-1:0] stage3_o
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    // First stage feeds only the second one
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= pin_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    assign stage2_o = s2_q;
    assign stage3_o = s3_q;
endmodule : dpc_pin_sync

// >>> dpc_host.sv
// Host controller driving a DDR pseudo-static DRAM over its 8-bit bus
// Function
// - 8-bit DDR bus, 16-bit word addressing
// - First two CA cycles: row, burst type
// - Third CA cycle: word within row
// - Strobe high in CA: longer latency
// - Host never crosses the die boundary
// - Select falling starts a transaction
// - Select rising ends a transaction
// - One select line per device
// - Differential clock references the crossing
// - Clock may stop between transfers
// - Command, address, data share eight lines
// - Host drives strobe as write mask
// - CA bit 47: 1 read, 0 write
// - CA bit 45: 0 wrapped, 1 linear
`timescale 1ns/1ps
module dpc_host (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_write,
    input wire logic req_linear,
    input wire logic [dpc_pkg::ADDR_W-1:0] req_addr,
    input wire logic [7:0] req_len,
    input wire logic wr_valid,
    output logic wr_ready,
    input wire logic [15:0] wr_data,
    input wire logic [1:0] wr_mask,
    output logic [15:0] rd_data,
    output logic rd_valid,
    output logic done,
    output logic refresh_seen,
    output logic mem_cs_n,
    output logic mem_ck,
    output logic mem_ck_n,
    output logic mem_reset_n,
    output logic [7:0] mem_dq_o,
    output logic mem_dq_oe,
    input wire logic [7:0] mem_dq_i,
    output logic mem_strobe_mask_o,
    output logic mem_strobe_mask_oe,
    input wire logic mem_strobe_mask_i
);
    typedef struct packed {
        dpc_pkg::dpc_state_t st;
        logic ph;
        logic ck;
        logic ck_n;
        logic cs_n;
        logic mrst_n;
        logic [7:0] dq;
        logic dq_oe;
        logic sm;
        logic sm_oe;
        logic [dpc_pkg::CNT_W-1:0] cnt;
        logic [2:0] idx;
        logic [47:0] ca;
        logic wr;
        logic [dpc_pkg::LEN_W-1:0] len;
        logic hi;
        logic [7:0] wlo;
        logic wmlo;
        logic [7:0] rhi;
        logic [15:0] rdat;
        logic rvld;
        logic dn;
        logic refr;
        logic last_sm;
        logic pend;
    } dpc_host_state_t;

    dpc_host_state_t s_q;
    dpc_host_state_t s_d;
    logic [8:0] sync2;
    logic [8:0] sync3;
    logic sm_stable;

    // Strobe and data pass the same pipeline so their skew is kept
    dpc_pin_sync #(.W(9)) u_sync (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .pin_i({mem_strobe_mask_i, mem_dq_i}),
        .stage2_o(sync2),
        .stage3_o(sync3)
    );

    assign sm_stable = (sync2[8] == sync3[8]);

    // Command-address word: direction, space, burst, row and column
    function automatic logic [47:0] ca_build(input logic wr, input logic lin,
                                             input logic [dpc_pkg::ADDR_W-1:0] a);
        logic [47:0] c;
        c = '0;
        c[dpc_pkg::CA_RW_BIT] = ~wr;
        c[dpc_pkg::CA_SPACE_BIT] = 1'b0;
        c[dpc_pkg::CA_BURST_BIT] = lin;
        c[dpc_pkg::CA_ROW_LSB +: (dpc_pkg::ADDR_W - dpc_pkg::CA_COL_W)] =
            a[dpc_pkg::ADDR_W-1:dpc_pkg::CA_COL_W];
        c[dpc_pkg::CA_COL_W-1:0] = a[dpc_pkg::CA_COL_W-1:0];
        return c;
    endfunction : ca_build

    // Words left before the die end; linear bursts are clipped there
    function automatic logic [dpc_pkg::LEN_W-1:0] die_clip(input logic lin,
            input logic [dpc_pkg::ADDR_W-1:0] a, input logic [7:0] n);
        logic [dpc_pkg::DIE_LOG2:0] room;
        logic [dpc_pkg::LEN_W-1:0] want;
        room = {1'b1, {dpc_pkg::DIE_LOG2{1'b0}}} - {1'b0, a[dpc_pkg::DIE_LOG2-1:0]};
        want = (n == 8'h00) ? 9'h001 : {1'b0, n};
        if (lin && room < {{(dpc_pkg::DIE_LOG2 + 1 - dpc_pkg::LEN_W){1'b0}}, want}) begin
            return room[dpc_pkg::LEN_W-1:0];
        end
        return want;
    endfunction : die_clip

    // Whole controller: one next-state copy of the state struct
    always_comb begin
        s_d = s_q;
        s_d.rvld = 1'b0;
        s_d.dn = 1'b0;
        case (s_q.st)
            dpc_pkg::ST_RESET: begin
                s_d.mrst_n = 1'b0;
                if (s_q.cnt == 8'(dpc_pkg::MRST_CYC - 1)) begin
                    s_d.mrst_n = 1'b1;
                    s_d.cnt = '0;
                    s_d.st = dpc_pkg::ST_IDLE;
                end else begin
                    s_d.cnt = s_q.cnt + 8'h01;
                end
            end
            dpc_pkg::ST_IDLE: begin
                // select falls with the clock idle low
                if (req_valid) begin
                    s_d.ca = ca_build(req_write, req_linear, req_addr);
                    s_d.wr = req_write;
                    // never run past the die end
                    s_d.len = die_clip(req_linear, req_addr, req_len);
                    s_d.cs_n = 1'b0;
                    s_d.ph = 1'b0;
                    s_d.idx = 3'h0;
                    s_d.dq_oe = 1'b1;
                    s_d.st = dpc_pkg::ST_CA;
                end
            end
            dpc_pkg::ST_CA: begin
                // command and address on the data lines, centred on edges
                if (!s_q.ph) begin
                    s_d.dq = s_q.ca[8'(47 - 8 * s_q.idx) -: 8];
                end else begin
                    s_d.ck = ~s_q.ck;
                    if (s_q.idx == 3'(dpc_pkg::CA_BYTES - 1)) begin
                        // strobe high during CA asks for the longer wait
                        s_d.refr = sync3[8] & sm_stable;
                        s_d.cnt = (sync3[8] & sm_stable) ?
                            8'(dpc_pkg::LAT_EDGES_REFRESH - 1) : 8'(dpc_pkg::LAT_EDGES - 1);
                        s_d.st = dpc_pkg::ST_LAT;
                    end else begin
                        s_d.idx = s_q.idx + 3'h1;
                    end
                end
                s_d.ph = ~s_q.ph;
            end
            dpc_pkg::ST_LAT: begin
                // latency edges keep running before data moves
                s_d.dq_oe = 1'b0;
                if (s_q.ph) begin
                    s_d.ck = ~s_q.ck;
                    if (s_q.cnt == 8'h00) begin
                        s_d.st = s_q.wr ? dpc_pkg::ST_WRITE : dpc_pkg::ST_READ;
                        s_d.last_sm = sync3[8];
                        s_d.hi = 1'b1;
                        s_d.cnt = 8'(dpc_pkg::RD_IDLE_CYC);
                    end else begin
                        s_d.cnt = s_q.cnt - 8'h01;
                    end
                end
                s_d.ph = ~s_q.ph;
            end
            dpc_pkg::ST_WRITE: begin
                if (!s_q.ph) begin
                    if (s_q.hi && s_q.len == 9'h000) begin
                        // last word gone: release lines, then deselect
                        s_d.dq_oe = 1'b0;
                        s_d.sm_oe = 1'b0;
                        s_d.cnt = '0;
                        s_d.st = dpc_pkg::ST_END;
                    end else if (s_q.hi) begin
                        // no data yet: hold the clock low instead of sending
                        if (wr_valid) begin
                            // upper byte first, lower byte kept for next edge
                            s_d.dq = wr_data[15:8];
                            s_d.sm = wr_mask[1];
                            s_d.wlo = wr_data[7:0];
                            s_d.wmlo = wr_mask[0];
                            s_d.dq_oe = 1'b1;
                            s_d.sm_oe = 1'b1;
                            s_d.ph = 1'b1;
                        end
                    end else begin
                        s_d.dq = s_q.wlo;
                        s_d.sm = s_q.wmlo;
                        s_d.ph = 1'b1;
                    end
                end else begin
                    s_d.ck = ~s_q.ck;
                    s_d.ph = 1'b0;
                    s_d.hi = ~s_q.hi;
                    if (!s_q.hi) begin
                        // Lines stay driven one more cycle for hold after the edge
                        s_d.len = s_q.len - 9'h001;
                    end
                end
            end
            dpc_pkg::ST_READ: begin
                // lines released; clock runs until all words arrive
                if (s_q.ph) begin
                    s_d.ck = ~s_q.ck;
                end
                s_d.ph = ~s_q.ph;
                s_d.cnt = s_q.cnt - 8'h01;
                // Strobe change seen; data taken one cycle later, mid-byte
                if (sm_stable && sync3[8] != s_q.last_sm) begin
                    s_d.last_sm = sync3[8];
                    s_d.pend = 1'b1;
                    s_d.cnt = 8'(dpc_pkg::RD_IDLE_CYC);
                end
                if (s_q.pend) begin
                    s_d.pend = 1'b0;
                    // two bytes pair into one word, first byte on top
                    if (s_q.hi) begin
                        s_d.rhi = sync3[7:0];
                        s_d.hi = 1'b0;
                    end else begin
                        s_d.rdat = {s_q.rhi, sync3[7:0]};
                        s_d.rvld = 1'b1;
                        s_d.hi = 1'b1;
                        s_d.len = s_q.len - 9'h001;
                    end
                end
                // Stalled device would hang the bus; give up after silence
                if ((s_q.pend && !s_q.hi && s_q.len == 9'h001) || s_q.cnt == 8'h00) begin
                    s_d.st = dpc_pkg::ST_END;
                    s_d.cnt = '0;
                    s_d.pend = 1'b0;
                end
            end
            dpc_pkg::ST_END: begin
                // select rises whatever the burst progress
                s_d.cs_n = 1'b1;
                s_d.ck = 1'b0;
                s_d.ph = 1'b0;
                s_d.dq_oe = 1'b0;
                s_d.sm_oe = 1'b0;
                s_d.sm = 1'b0;
                if (s_q.cnt == 8'(dpc_pkg::CS_HIGH_CYC - 1)) begin
                    s_d.dn = 1'b1;
                    s_d.st = dpc_pkg::ST_IDLE;
                end else begin
                    s_d.cnt = s_q.cnt + 8'h01;
                end
            end
            default: begin
                s_d.st = dpc_pkg::ST_END;
                s_d.cnt = '0;
            end
        endcase
        // complement clock crosses the true one at every edge
        s_d.ck_n = ~s_d.ck;
    end

    // State register; reset holds the memory in its own reset
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
            s_q.st <= dpc_pkg::ST_RESET;
            s_q.cs_n <= 1'b1;
            s_q.ck_n <= 1'b1;
            s_q.hi <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign req_ready = (s_q.st == dpc_pkg::ST_IDLE);
    assign wr_ready = (s_q.st == dpc_pkg::ST_WRITE) && !s_q.ph && s_q.hi && wr_valid &&
                      (s_q.len != 9'h000);
    assign rd_data = s_q.rdat;
    assign rd_valid = s_q.rvld;
    assign done = s_q.dn;
    assign refresh_seen = s_q.refr;
    // this controller owns one dedicated select
    assign mem_cs_n = s_q.cs_n;
    assign mem_ck = s_q.ck;
    assign mem_ck_n = s_q.ck_n;
    assign mem_reset_n = s_q.mrst_n;
    assign mem_dq_o = s_q.dq;
    assign mem_dq_oe = s_q.dq_oe;
    assign mem_strobe_mask_o = s_q.sm;
    assign mem_strobe_mask_oe = s_q.sm_oe;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    sequence ca_start;
        $fell(mem_cs_n);
    endsequence
    sequence ca_first_byte;
        s_q.st == dpc_pkg::ST_CA && s_q.idx == 3'h0 && s_q.ph;
    endsequence

    chk_select_starts_ca: assert property (
        ca_start |-> s_q.st == dpc_pkg::ST_CA && !mem_ck ##12 s_q.st == dpc_pkg::ST_LAT)
        else $error("select fall not followed by six CA edges");
    chk_rw_bit_sent: assert property (
        ca_first_byte |-> mem_dq_o[7] == ~s_q.wr && mem_dq_oe)
        else $error("direction bit wrong in first CA byte");
    chk_burst_bit_sent: assert property (
        ca_first_byte |-> mem_dq_o[5] == s_q.ca[dpc_pkg::CA_BURST_BIT])
        else $error("burst bit wrong in first CA byte");
    chk_clock_idle_low: assert property (
        mem_cs_n |-> !mem_ck && mem_ck_n)
        else $error("clock not idle while deselected");
    chk_clock_complement: assert property (
        mem_ck_n == ~mem_ck)
        else $error("complement clock not opposite");
    chk_latency_length: assert property (
        $rose(s_q.st == dpc_pkg::ST_LAT) |->
        (s_q.refr ? (s_q.cnt == 8'(dpc_pkg::LAT_EDGES_REFRESH - 1))
                  : (s_q.cnt == 8'(dpc_pkg::LAT_EDGES - 1))))
        else $error("latency count not matched to refresh flag");
    chk_mask_only_write: assert property (
        mem_strobe_mask_oe |-> s_q.st == dpc_pkg::ST_WRITE)
        else $error("strobe driven outside write data");
    chk_read_released: assert property (
        s_q.st == dpc_pkg::ST_READ |-> !mem_dq_oe && !mem_strobe_mask_oe)
        else $error("lines driven during read data");
    chk_end_deselect: assert property (
        s_q.st == dpc_pkg::ST_END |=> mem_cs_n)
        else $error("select not raised at end");
    chk_die_bound: assert property (
        $rose(s_q.st == dpc_pkg::ST_CA) && s_q.ca[dpc_pkg::CA_BURST_BIT] |->
        s_q.len != 9'h000)
        else $error("linear burst length clipped to zero");
endmodule : dpc_host

// >>> dpc_mem_model.sv
// Behavioural DDR pSRAM device model facing the host controller
`timescale 1ns/1ps
module dpc_mem_model (
    input wire logic mem_cs_n,
    input wire logic mem_ck,
    input wire logic mem_reset_n,
    input wire logic [7:0] dq_i,
    output logic [7:0] dq_o,
    output logic dq_oe,
    input wire logic sm_i,
    output logic sm_o,
    output logic sm_oe,
    input wire logic refresh,
    output logic [47:0] last_ca
);
    logic [15:0] mem [int];
    logic [24:0] b;
    logic [24:0] a;
    logic [15:0] w;
    int e = 0;
    int k;
    int lat = 12;
    initial begin
        dq_o = 8'h00;
        dq_oe = 1'h0;
        sm_o = 1'h0;
        sm_oe = 1'h0;
        last_ca = 48'h0;
    end
    // select fall opens CA, strobe flags refresh
    always @(negedge mem_cs_n) begin
        e = 0;
        lat = refresh ? 24 : 12;
        sm_o = refresh;
        sm_oe = mem_reset_n;
    end
    // deselect or reset floats every line
    // Level-sensitive: a clock edge racing the deselect cannot leave a line driven
    always @(mem_cs_n or mem_reset_n or mem_ck) begin
        if (mem_cs_n || !mem_reset_n) begin
            dq_oe = 1'h0;
            sm_oe = 1'h0;
            e = 0;
        end
    end
    // one byte on each bus clock edge, CA then data
    always @(mem_ck) begin
        if (!mem_cs_n && mem_reset_n) begin
            k = e - 6 - lat;
            // six CA bytes, first byte on top
            if (e < 6) last_ca = {last_ca[39:0], dq_i};
            if (e == 5) begin
                sm_oe = last_ca[47];
                sm_o = 1'h0;
            end
            // wrap in 8 words, or linear within die
            b = {last_ca[37:16], last_ca[2:0]};
            a = last_ca[45] ? {b[24], b[23:0] + 24'(k / 2)} : {b[24:3], b[2:0] + 3'(k / 2)};
            w = mem.exists(a) ? mem[a] : a[15:0] ^ 16'h5A3C;
            // byte and strobe edge change together
            if (k >= 0 && last_ca[47]) begin
                dq_o = k[0] ? w[7:0] : w[15:8];
                dq_oe = 1'h1;
                sm_o = ~sm_o;
            end
            if (k >= 0 && !last_ca[47] && !sm_i) begin
                if (k[0]) w[7:0] = dq_i;
                else w[15:8] = dq_i;
                mem[a] = w;
            end
            e = e + 1;
        end
    end
endmodule : dpc_mem_model

// >>> tb_top.sv
// Self-checking bench: host controller against the device model
`timescale 1ns/1ps
module tb_top;
    logic ref_clk = 1'h0;
    logic rst_n = 1'h0;
    logic req_valid = 1'h0, req_write = 1'h0, req_linear = 1'h0, wr_valid = 1'h0;
    logic [dpc_pkg::ADDR_W-1:0] req_addr = 25'h0;
    logic [7:0] req_len = 8'h00;
    logic [15:0] wr_data = 16'h0000;
    logic [1:0] wr_mask = 2'h0;
    logic refresh = 1'h0;
    logic req_ready, wr_ready, rd_valid, done, refresh_seen, mem_cs_n, mem_ck, mem_ck_n;
    logic mem_reset_n, mem_dq_oe, mem_strobe_mask_o, mem_strobe_mask_oe, mem_strobe_mask_i;
    logic m_dq_oe, m_sm_o, m_sm_oe;
    logic [7:0] mem_dq_o, mem_dq_i, m_dq_o;
    logic [7:0] junk = 8'hA5;
    logic [15:0] rd_data;
    logic [47:0] last_ca;
    logic [15:0] shadow [int];
    int miscompares = 0;
    int total_checks = 0;
    // Reference clock, 25 ns
    always #12.5 ref_clk = ~ref_clk;
    // Undriven lines show a pattern that moves every cycle
    always @(posedge ref_clk) junk <= junk + 8'h3B;
    assign mem_dq_i = mem_dq_oe ? mem_dq_o : (m_dq_oe ? m_dq_o : junk);
    assign mem_strobe_mask_i = mem_strobe_mask_oe ? mem_strobe_mask_o
                                                  : (m_sm_oe ? m_sm_o : junk[0]);
    dpc_host dut (
        .ref_clk, .rst_n, .req_valid, .req_ready, .req_write, .req_linear, .req_addr,
        .req_len, .wr_valid, .wr_ready, .wr_data, .wr_mask, .rd_data, .rd_valid, .done,
        .refresh_seen, .mem_cs_n, .mem_ck, .mem_ck_n, .mem_reset_n, .mem_dq_o, .mem_dq_oe,
        .mem_dq_i, .mem_strobe_mask_o, .mem_strobe_mask_oe, .mem_strobe_mask_i
    );
    dpc_mem_model mdl (
        .mem_cs_n, .mem_ck, .mem_reset_n, .dq_i(mem_dq_i), .dq_o(m_dq_o), .dq_oe(m_dq_oe),
        .sm_i(mem_strobe_mask_i), .sm_o(m_sm_o), .sm_oe(m_sm_oe), .refresh, .last_ca
    );
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : print_verdict
    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_bit(input logic got, input logic exp);
        chk({47'h0, got}, {47'h0, exp});
    endtask : chk_bit
    // A wait that runs out is a failure of its own
    task automatic lapse;
        chk(48'h0, 48'h1);
        print_verdict();
    endtask : lapse
    function automatic logic [24:0] addr_of(logic [24:0] b, logic lin, int j);
        return lin ? {b[24], b[23:0] + 24'(j)} : {b[24:3], b[2:0] + 3'(j)};
    endfunction : addr_of
    // Linear bursts stop at the die end, zero length means one
    function automatic int eff_len(logic [24:0] b, logic lin, logic [7:0] n);
        int m;
        int room;
        m = (n == 8'h00) ? 1 : int'(n);
        room = 32'h0100_0000 - int'(b[23:0]);
        return (lin && m > room) ? room : m;
    endfunction : eff_len
    function automatic logic [47:0] ca_of(logic wr, logic lin, logic [24:0] b);
        return {~wr, 1'h0, lin, 7'h00, b[24:3], 13'h0000, b[2:0]};
    endfunction : ca_of
    function automatic logic [15:0] exp_word(logic [24:0] a);
        return shadow.exists(a) ? shadow[a] : a[15:0] ^ 16'h5A3C;
    endfunction : exp_word
    task automatic request(input logic wr, lin, input logic [24:0] b, input logic [7:0] n,
                           input logic rf);
        int t;
        t = 0;
        @(negedge ref_clk);
        while (req_ready !== 1'h1) begin
            if (++t > 400) lapse();
            @(negedge ref_clk);
        end
        refresh = rf;
        req_write = wr;
        req_linear = lin;
        req_addr = b;
        req_len = n;
        req_valid = 1'h1;
        @(negedge ref_clk);
        req_valid = 1'h0;
    endtask : request
    // One transaction; write words arrive with random stalls
    task automatic xfer(input logic wr, lin, input logic [24:0] b, input logic [7:0] n,
                        input logic rf);
        int cnt;
        int t;
        int j;
        logic sent;
        logic [15:0] w;
        cnt = eff_len(b, lin, n);
        t = 0;
        j = 0;
        sent = 1'h0;
        request(wr, lin, b, n, rf);
        while (done !== 1'h1) begin
            if (++t > 3000) lapse();
            if (rd_valid === 1'h1) begin
                chk(48'(rd_data), 48'(exp_word(addr_of(b, lin, j))));
                j++;
            end
            if (sent || !wr_valid) begin
                wr_valid = wr && j < cnt && $urandom_range(0, 2) != 0;
                wr_data = 16'($urandom);
                wr_mask = 2'($urandom);
            end
            sent = 1'h0;
            // Ready follows valid combinationally; a word raised now may go at once
            #1;
            if (wr_ready === 1'h1) begin
                w = exp_word(addr_of(b, lin, j));
                if (!wr_mask[1]) w[15:8] = wr_data[15:8];
                if (!wr_mask[0]) w[7:0] = wr_data[7:0];
                shadow[addr_of(b, lin, j)] = w;
                j++;
                sent = 1'h1;
            end
            @(negedge ref_clk);
        end
        chk(48'(j), 48'(cnt));
        chk(last_ca, ca_of(wr, lin, b));
        chk_bit(refresh_seen, rf);
        chk_bit(mem_cs_n & ~m_dq_oe & ~m_sm_oe, 1'h1);
        chk_bit(mem_ck_n, ~mem_ck);
    endtask : xfer
    // Reset, corner cases, then random write and read-back pairs
    initial begin
        logic [24:0] b;
        logic lin;
        logic rf;
        logic [7:0] n;
        void'($urandom(70));
        repeat (2) @(negedge ref_clk);
        chk_bit(mem_reset_n | mem_dq_oe | mem_strobe_mask_oe, 1'h0);
        chk_bit(m_dq_oe | m_sm_oe | ~mem_cs_n, 1'h0);
        rst_n = 1'h1;
        xfer(1'h1, 1'h1, 25'h0000010, 8'h04, 1'h0);
        xfer(1'h0, 1'h1, 25'h0000010, 8'h04, 1'h0);
        xfer(1'h1, 1'h0, 25'h1000026, 8'h05, 1'h1);
        xfer(1'h0, 1'h0, 25'h1000025, 8'h08, 1'h1);
        xfer(1'h0, 1'h1, 25'h0FFFFFE, 8'h04, 1'h0);
        xfer(1'h1, 1'h1, 25'h1FFFFFF, 8'h03, 1'h0);
        xfer(1'h0, 1'h0, 25'h0000000, 8'h00, 1'h0);
        for (int i = 0; i < 8; i++) begin
            b = 25'($urandom);
            lin = 1'($urandom);
            rf = 1'($urandom);
            n = 8'($urandom_range(1, 8));
            xfer(1'h1, lin, b, n, rf);
            xfer(1'h0, lin, b, n, ~rf);
        end
        // Reset lands during the latency of a read
        request(1'h0, 1'h1, 25'h0000040, 8'h08, 1'h0);
        repeat (20) @(negedge ref_clk);
        rst_n = 1'h0;
        @(negedge ref_clk);
        chk_bit(mem_reset_n | mem_dq_oe | ~mem_cs_n, 1'h0);
        chk_bit(m_dq_oe | m_sm_oe, 1'h0);
        rst_n = 1'h1;
        xfer(1'h0, 1'h1, 25'h0000010, 8'h04, 1'h0);
        print_verdict();
    end
endmodule : tb_top
